// ==== design/ssp_top.sv ====
// How it works
// [R1] eight bits shift out and in together
// [R2] four clock modes, role, rate, select
// [R3] master drives clock, slave samples it
// [R4] most significant bit goes first
// [R5] full word copies to buffer, flags set
// [R6] next word starts before buffer read
// [R7] busy write dropped, collision flag set
// [R8] software alone clears collision flag
// [R9] general call is all zero byte
// [R10] general call only when enabled
// [R11] after start compare seven address bits
// [R12] buffer-full at eighth, flag at ack
// [R13] software reads buffer for address source
// [R14] ten-bit mode raises update-address flag
// [R15] general call skips second address byte
// [R16] start/stop bits clear on disable
// [R17] master takes bus only when free
// [R18] master drives scl and sda itself
// [R19] master events raise interrupt flag
// [R20] master write starts a transfer
`timescale 1ns/1ps
`default_nettype none
`include "ssp_regs.svh"

module ssp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_ff[rd_ff];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module ssp_top (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // configuration
   input  wire ssp_pkg::ssp_cfg_t cfg,
   input  wire logic [7:0]       own_address_register,
   // software write to buffer register (through fifo)
   input  wire logic             tx_valid,
   output logic                  tx_ready,
   input  wire logic [7:0]       tx_data,
   // software read of buffer register
   input  wire logic             rd_strobe,
   output logic [7:0]            buffer_register,
   // software flag clears
   input  wire logic             clr_interrupt,
   input  wire logic             clr_collision,
   input  wire logic             clr_update_address,
   // i2c master commands
   input  wire logic             start_req,
   input  wire logic             stop_req,
   output logic                  bus_granted,
   // status
   output ssp_pkg::ssp_stat_t    status,
   // spi pins
   input  wire logic             sck_in,
   output logic                  sck_out,
   output logic                  sck_oe,
   input  wire logic             select_n_in,
   input  wire logic             serial_in_pin,
   output logic                  serial_out_pin,
   // i2c pins (open drain)
   input  wire logic             scl_in,
   output logic                  scl_oe,
   input  wire logic             sda_in,
   output logic                  sda_oe
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] sck_s_ff, ss_s_ff, sdi_s_ff, scl_s_ff, sda_s_ff;
   logic sck_q_ff, ss_q_ff, sdi_q_ff, scl_q_ff, sda_q_ff;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sck_s_ff <= 3'h0;
         ss_s_ff  <= 3'h7;
         sdi_s_ff <= 3'h0;
         scl_s_ff <= 3'h7;
         sda_s_ff <= 3'h7;
      end else begin
         sck_s_ff <= {sck_s_ff[1:0], sck_in};
         ss_s_ff  <= {ss_s_ff[1:0], select_n_in};
         sdi_s_ff <= {sdi_s_ff[1:0], serial_in_pin};
         scl_s_ff <= {scl_s_ff[1:0], scl_in};
         sda_s_ff <= {sda_s_ff[1:0], sda_in};
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sck_q_ff <= 1'b0;
         ss_q_ff  <= 1'b1;
         sdi_q_ff <= 1'b0;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         if (sck_s_ff[2] == sck_s_ff[1]) sck_q_ff <= sck_s_ff[2];
         if (ss_s_ff[2] == ss_s_ff[1]) ss_q_ff <= ss_s_ff[2];
         if (sdi_s_ff[2] == sdi_s_ff[1]) sdi_q_ff <= sdi_s_ff[2];
         if (scl_s_ff[2] == scl_s_ff[1]) scl_q_ff <= scl_s_ff[2];
         if (sda_s_ff[2] == sda_s_ff[1]) sda_q_ff <= sda_s_ff[2];
      end
   end

   // ----------------------------------------
   // spi clock generation and edges
   // ----------------------------------------
   logic [`SSP_DIV_W-1:0] div_ff;
   logic [`SSP_DIV_W-1:0] half;
   logic       mclk_ff;
   logic       sck_prev_ff;
   logic       spi_mode, spi_master;
   logic       cur_sck, lead_edge, trail_edge, sel_ok;
   ssp_pkg::ssp_state_t state_ff;
   logic [7:0] shift_register_ff;
   logic [3:0] bit_cnt_ff;
   logic       out_ff;

   assign spi_mode   = cfg.enable && !cfg.i2c_mode;
   assign spi_master = spi_mode && cfg.master;
   always_comb begin
      case (cfg.clk_rate)
         2'h0:    half = `SSP_DIV_W'(`SSP_HALF_DIV4);
         2'h1:    half = `SSP_DIV_W'(`SSP_HALF_DIV16);
         default: half = `SSP_HALF_DIV64;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_ff  <= '0;
         mclk_ff <= 1'b0;
      end else if (spi_master && state_ff == ssp_pkg::SSP_SHIFT) begin // [R3]
         if (div_ff == half - 1'b1) begin
            div_ff  <= '0;
            mclk_ff <= !mclk_ff;
         end else begin
            div_ff <= div_ff + 1'b1;
         end
      end else begin
         div_ff  <= '0;
         mclk_ff <= 1'b0;
      end
   end

   // clock polarity applied on the active level, idle stays at polarity
   assign cur_sck = cfg.master ? mclk_ff : (sck_q_ff ^ cfg.clk_idle_high); // [R2]
   always_ff @(posedge clk or posedge reset) begin
      if (reset) sck_prev_ff <= 1'b0;
      else       sck_prev_ff <= cur_sck;
   end
   assign lead_edge  = cur_sck && !sck_prev_ff;
   assign trail_edge = !cur_sck && sck_prev_ff;
   assign sel_ok     = cfg.master || !cfg.use_select || !ss_q_ff; // [R3]

   // ----------------------------------------
   // shift engine
   // ----------------------------------------
   logic       busy, load_word, sample_edge, shift_edge, word_done;
   logic [7:0] fifo_data;
   logic       fifo_valid;
   logic       fifo_pop;

   assign busy        = (state_ff != ssp_pkg::SSP_IDLE);
   // sample on leading edge unless exactly one of out-on-active and sample-end turns it round
   assign sample_edge = (cfg.out_on_active ^ cfg.sample_end) ? trail_edge : lead_edge; // [R2]
   // output edge follows out_on_active alone; sample_end only moves the sampling point
   assign shift_edge  = cfg.out_on_active ? lead_edge : trail_edge; // [R2]
   assign load_word   = spi_mode && !busy && fifo_valid && (cfg.master || sel_ok); // [R20]
   assign fifo_pop    = load_word;
   assign word_done   = state_ff == ssp_pkg::SSP_SHIFT && sample_edge && sel_ok
                        && bit_cnt_ff == 4'h7;
   ssp_fifo #(.WIDTH(`SSP_WORD_BITS), .DEPTH(`SSP_FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (tx_valid && !busy),
      .in_ready  (tx_ready),
      .in_data   (tx_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff          <= ssp_pkg::SSP_IDLE;
         shift_register_ff <= `SSP_BUF_RESET;
         bit_cnt_ff        <= 4'h0;
         out_ff            <= 1'b0;
      end else if (!spi_mode) begin
         state_ff   <= ssp_pkg::SSP_IDLE;
         bit_cnt_ff <= 4'h0;
      end else begin
         case (state_ff)
            ssp_pkg::SSP_IDLE: begin
               if (load_word) begin
                  shift_register_ff <= fifo_data;
                  out_ff            <= fifo_data[7]; // [R4]
                  bit_cnt_ff        <= 4'h0;
                  state_ff          <= ssp_pkg::SSP_SHIFT;
               end
            end
            ssp_pkg::SSP_SHIFT: begin
               if (sample_edge && sel_ok) begin
                  shift_register_ff <= {shift_register_ff[6:0], sdi_q_ff}; // [R1] [R4]
                  bit_cnt_ff        <= bit_cnt_ff + 4'h1;
                  if (word_done) state_ff <= ssp_pkg::SSP_DONE;
               end
               // sampling on the same edge moves the shifter now: take the next bit
               if (shift_edge && sel_ok) begin
                  out_ff <= sample_edge ? shift_register_ff[6] : shift_register_ff[7];
               end
            end
            ssp_pkg::SSP_DONE: state_ff <= ssp_pkg::SSP_IDLE;
            default:           state_ff <= ssp_pkg::SSP_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // i2c start/stop, address match
   // ----------------------------------------
   logic scl_prev_ff, sda_prev_ff, start_ev, stop_ev;
   logic start_seen_ff, stop_seen_ff;
   logic [7:0] i2c_sr_ff;
   logic [3:0] i2c_cnt_ff;
   logic       addr_phase_ff, gcall_ff, ack_hold_ff, gc_match, own_match;
   logic       i2c_on, ack_fall, scl_fall, ack_drive_ff, m_sda_ff, m_scl_ff;

   assign i2c_on   = cfg.enable && cfg.i2c_mode;
   assign start_ev = i2c_on && scl_q_ff && sda_prev_ff && !sda_q_ff;
   assign stop_ev  = i2c_on && scl_q_ff && !sda_prev_ff && sda_q_ff;
   assign gc_match = cfg.general_call_enable && i2c_sr_ff == `SSP_GCALL_ADDR; // [R9] [R10]
   assign own_match = i2c_sr_ff[7:1] == own_address_register[7:1];
   assign scl_fall  = scl_prev_ff && !scl_q_ff;
   // ack is held from the fall after bit eight to the fall ending the ack clock
   assign ack_fall  = ack_hold_ff && ack_drive_ff && scl_fall;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_prev_ff <= scl_q_ff;
         sda_prev_ff <= sda_q_ff;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         start_seen_ff <= 1'b0;
         stop_seen_ff  <= 1'b0;
      end else if (!cfg.enable) begin // [R16]
         start_seen_ff <= 1'b0;
         stop_seen_ff  <= 1'b0;
      end else if (start_ev) begin
         start_seen_ff <= 1'b1;
         stop_seen_ff  <= 1'b0;
      end else if (stop_ev) begin
         start_seen_ff <= 1'b0;
         stop_seen_ff  <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         i2c_sr_ff     <= 8'h00;
         i2c_cnt_ff    <= 4'h0;
         addr_phase_ff <= 1'b0;
         gcall_ff      <= 1'b0;
         ack_hold_ff   <= 1'b0;
         ack_drive_ff  <= 1'b0;
      end else if (!i2c_on || start_ev) begin
         i2c_cnt_ff    <= 4'h0;
         addr_phase_ff <= start_ev; // [R11]
         gcall_ff      <= 1'b0;
         ack_hold_ff   <= 1'b0;
         ack_drive_ff  <= 1'b0;
      end else begin
         if (scl_q_ff && !scl_prev_ff && i2c_cnt_ff < 4'h8) begin
            i2c_sr_ff  <= {i2c_sr_ff[6:0], sda_q_ff};
            i2c_cnt_ff <= i2c_cnt_ff + 4'h1;
         end
         if (i2c_cnt_ff == 4'h8 && !ack_hold_ff) begin
            ack_hold_ff <= addr_phase_ff ? (gc_match || own_match) : 1'b1;
            gcall_ff    <= addr_phase_ff && gc_match;
            if (!(addr_phase_ff && !(gc_match || own_match))) i2c_cnt_ff <= 4'h9;
            else                                              i2c_cnt_ff <= 4'hF;
         end
         if (ack_hold_ff && !ack_drive_ff && scl_fall) ack_drive_ff <= 1'b1; // [R12]
         if (ack_fall) begin
            ack_hold_ff   <= 1'b0;
            ack_drive_ff  <= 1'b0;
            i2c_cnt_ff    <= 4'h0;
            // general call ends the address phase even in ten-bit mode
            addr_phase_ff <= addr_phase_ff && cfg.ten_bit && !gcall_ff && !i2c_sr_ff[0]
                             && i2c_sr_ff[7:3] == 5'h1E; // [R15]
         end
      end
   end
   // stalled count 4'h9 waits for ack; 4'hF ignores the rest of the frame
   assign sda_oe = ack_drive_ff || m_sda_ff; // [R18]
   assign scl_oe = m_scl_ff;

   // ----------------------------------------
   // i2c master bus control
   // ----------------------------------------
   assign bus_granted = stop_seen_ff || (!start_seen_ff && !stop_seen_ff); // [R17]
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         m_sda_ff <= 1'b0;
         m_scl_ff <= 1'b0;
      end else if (!(i2c_on && cfg.master)) begin
         m_sda_ff <= 1'b0;
         m_scl_ff <= 1'b0;
      end else if (start_req && bus_granted) begin
         m_sda_ff <= 1'b1; // [R18]
         // scl follows one cycle later so the start is seen with scl high
         m_scl_ff <= m_sda_ff;
      end else if (stop_req) begin
         m_sda_ff <= 1'b0;
         m_scl_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // buffer and flags
   // ----------------------------------------
   logic [7:0] buf_ff;
   logic bf_ff, pif_ff, write_collision_flag_ff, ua_ff, gch_ff, i2c_byte, set_pif, set_ua;

   assign i2c_byte = i2c_on && i2c_cnt_ff == 4'h8 && !ack_hold_ff
                     && !(addr_phase_ff && !(gc_match || own_match));
   assign set_ua   = ack_fall && addr_phase_ff && cfg.ten_bit && !gcall_ff; // [R14] [R15]
   assign set_pif  = (state_ff == ssp_pkg::SSP_DONE)
                     || ack_fall // [R12]
                     || (cfg.master && (start_ev || stop_ev)); // [R19]

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         buf_ff  <= `SSP_BUF_RESET;
         bf_ff   <= 1'b0;
         pif_ff  <= 1'b0;
         write_collision_flag_ff <= 1'b0;
         ua_ff   <= 1'b0;
         gch_ff  <= 1'b0;
      end else begin
         // double buffering: new word lands here while shifter restarts
         if (state_ff == ssp_pkg::SSP_DONE) buf_ff <= shift_register_ff; // [R5] [R6]
         else if (i2c_byte)                buf_ff <= i2c_sr_ff; // [R12] [R13]
         if (state_ff == ssp_pkg::SSP_DONE || i2c_byte) bf_ff <= 1'b1; // [R5]
         else if (rd_strobe)                             bf_ff <= 1'b0;
         if (set_pif)            pif_ff <= 1'b1; // [R5] [R19]
         else if (clr_interrupt) pif_ff <= 1'b0;
         // collision only clears on software request
         if (busy && tx_valid)   write_collision_flag_ff <= 1'b1; // [R7] [R8]
         else if (clr_collision) write_collision_flag_ff <= 1'b0;
         if (set_ua)                  ua_ff <= 1'b1; // [R14]
         else if (clr_update_address) ua_ff <= 1'b0;
         if (ack_fall && addr_phase_ff) gch_ff <= gcall_ff;
      end
   end

   assign buffer_register = buf_ff;
   assign sck_oe          = spi_master; // [R3]
   assign sck_out         = mclk_ff ^ cfg.clk_idle_high;
   assign serial_out_pin  = out_ff;
   assign status = '{buffer_full_flag: bf_ff, port_interrupt_flag: pif_ff,
                     write_collision_flag: write_collision_flag_ff, update_address_flag: ua_ff,
                     start_seen: start_seen_ff, stop_seen: stop_seen_ff,
                     gcall_hit: gch_ff, busy: busy};

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_word_to_buf: assert property (@(posedge clk) disable iff (reset) // [R5]
      state_ff == ssp_pkg::SSP_DONE |=> bf_ff && pif_ff && buf_ff == $past(shift_register_ff))
      else $error("word not moved to buffer");
   a_busy_write_drop: assert property (@(posedge clk) disable iff (reset) // [R7]
      busy && tx_valid |=> write_collision_flag_ff && $stable(u_fifo.cnt_ff))
      else $error("busy write not flagged");
   a_write_collision_flag_sticky: assert property (@(posedge clk) disable iff (reset) // [R8]
      write_collision_flag_ff && !clr_collision |=> write_collision_flag_ff)
      else $error("collision flag cleared by hardware");
   a_stop_clear: assert property (@(posedge clk) disable iff (reset) // [R16]
      !cfg.enable |=> !start_seen_ff && !stop_seen_ff)
      else $error("start/stop kept while disabled");
   a_grant_free: assert property (@(posedge clk) disable iff (reset) // [R17]
      $rose(m_sda_ff) |-> $past(bus_granted))
      else $error("master took a busy bus");
   a_ua_gcall: assert property (@(posedge clk) disable iff (reset) // [R15]
      ack_fall && gcall_ff |=> !ua_ff || $past(ua_ff))
      else $error("update address set on general call");
   a_sck_idle: assert property (@(posedge clk) disable iff (reset) // [R2]
      state_ff != ssp_pkg::SSP_SHIFT |=> sck_out == cfg.clk_idle_high)
      else $error("clock left idle level outside a word");
   a_ack_pif: assert property (@(posedge clk) disable iff (reset) // [R12]
      ack_fall |=> pif_ff)
      else $error("no interrupt at ack");
endmodule

`default_nettype wire

// ==== include/ssp_regs.svh ====
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
// ----------------------------------------
// sizes, general call address and reset values
// ----------------------------------------
`define SSP_WORD_BITS      8
`define SSP_FIFO_DEPTH     8
`define SSP_GCALL_ADDR     8'h00
`define SSP_BUF_RESET      8'h00
`define SSP_ADDR_RESET     8'h00
// master clock: half period in system cycles per rate code
`define SSP_HALF_DIV4      4'h2
`define SSP_HALF_DIV16     4'h8
`define SSP_HALF_DIV64     6'h20
`define SSP_DIV_W          6
`endif

// ==== include/ssp_pkg.sv ====
package ssp_pkg;
   // spi and i2c configuration
   typedef struct packed {
      logic       enable;
      logic       i2c_mode;
      logic       master;
      logic       clk_idle_high;
      logic       sample_end;
      logic       out_on_active;
      logic [1:0] clk_rate;
      logic       use_select;
      logic       general_call_enable;
      logic       ten_bit;
   } ssp_cfg_t;
   // status toward software
   typedef struct packed {
      logic buffer_full_flag;
      logic port_interrupt_flag;
      logic write_collision_flag;
      logic update_address_flag;
      logic start_seen;
      logic stop_seen;
      logic gcall_hit;
      logic busy;
   } ssp_stat_t;
   typedef enum logic [3:0] {
      SSP_IDLE  = 4'b0001,
      SSP_SHIFT = 4'b0010,
      SSP_ACK   = 4'b0100,
      SSP_DONE  = 4'b1000
   } ssp_state_t;
endpackage

// ==== dv/ssp_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// far-side spi data partner, clocked by whoever owns sck
// ----
module ssp_peer (
   // link
   input  wire logic       sck,
   input  wire logic       mosi,
   output logic            miso,
   // setup
   input  wire logic       cpol,
   input  wire logic       out_lead,
   input  wire logic       load,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte
);
   logic [7:0] sreg = 8'h00;
   int         ocnt = 8;
   initial miso = 1'b0;
   initial rx_byte = 8'h00;
   // past the last bit the line shows the inverse, so a late sample cannot pass
   task automatic drive_next();
      if (ocnt < 8) miso = sreg[7];
      else miso = ~miso;
      sreg = {sreg[6:0], 1'b0};
      ocnt++;
   endtask
   always @(posedge load) begin
      sreg = tx_byte;
      ocnt = 0;
      if (!out_lead) drive_next();
   end
   always @(sck) begin
      if ((sck != cpol) == out_lead) drive_next();
      else rx_byte = {rx_byte[6:0], mosi};
   end
endmodule
`default_nettype wire

// ==== dv/tb_ssp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_ssp_top;
   // ----
   // signals
   // ----
   logic              clk = 1'b0;
   logic              reset = 1'b1;
   ssp_pkg::ssp_cfg_t cfg = '0;
   ssp_pkg::ssp_stat_t status;
   logic [7:0]        own = 8'h00;
   logic [7:0]        tx_data = 8'h00;
   logic [7:0]        buffer_register;
   logic [7:0]        peer_tx = 8'h00;
   logic [7:0]        peer_rx;
   logic              tx_valid = 1'b0;
   logic              tx_ready;
   logic              rd_strobe = 1'b0;
   logic              clr_int = 1'b0;
   logic              clr_col = 1'b0;
   logic              clr_ua = 1'b0;
   logic              start_req = 1'b0;
   logic              bus_granted;
   logic              sck_out;
   logic              sck_oe;
   logic              select_n = 1'b1;
   logic              miso;
   logic              mosi;
   logic              scl_oe;
   logic              sda_oe;
   logic              lk = 1'b0;
   logic              peer_load = 1'b0;
   logic              m_scl_low = 1'b0;
   logic              m_sda_low = 1'b0;
   logic              ack;
   logic [7:0]        exp_q[$];
   int                err_count = 0;
   int                checked = 0;
   int                cycles = 0;
   int                seed;
   // open-drain lines with pull-ups
   wire logic         scl_w = ~(scl_oe | m_scl_low);
   wire logic         sda_w = ~(sda_oe | m_sda_low);
   wire logic         peer_sck = cfg.master ? sck_out : lk;

   always #10 clk = ~clk;

   ssp_top u_ssp_top (
      .clk(clk), .reset(reset), .cfg(cfg), .own_address_register(own),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .rd_strobe(rd_strobe), .buffer_register(buffer_register),
      .clr_interrupt(clr_int), .clr_collision(clr_col), .clr_update_address(clr_ua),
      .start_req(start_req), .stop_req(1'b0), .bus_granted(bus_granted),
      .status(status), .sck_in(lk), .sck_out(sck_out), .sck_oe(sck_oe),
      .select_n_in(select_n), .serial_in_pin(miso), .serial_out_pin(mosi),
      .scl_in(scl_w), .scl_oe(scl_oe), .sda_in(sda_w), .sda_oe(sda_oe));

   ssp_peer u_ssp_peer (
      .sck(peer_sck), .mosi(mosi), .miso(miso), .cpol(cfg.clk_idle_high),
      .out_lead(cfg.out_on_active), .load(peer_load), .tx_byte(peer_tx),
      .rx_byte(peer_rx));

   // ----
   // shared tasks
   // ----
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic clear_flags();
      @(negedge clk);
      {rd_strobe, clr_int, clr_col, clr_ua} = 4'hF;
      @(negedge clk);
      {rd_strobe, clr_int, clr_col, clr_ua} = 4'h0;
   endtask
   task automatic wait_busy(input logic v);
      int n;
      n = 0;
      while (status.busy !== v && n < 3000) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic write_word(input logic [7:0] d);
      int n;
      @(negedge clk);
      tx_data = d;
      tx_valid = 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(tx_ready === 1'b1 && status.busy !== 1'b1) && n < 50);
      @(negedge clk);
      tx_valid = 1'b0;
   endtask
   task automatic spi_xfer(input logic [7:0] d, input int half, input bit collide);
      logic [7:0] m;
      logic       dbl;
      logic       s;
      int         n;
      m = 8'($random(seed));
      dbl = status.buffer_full_flag;
      if (dbl !== 1'b1) exp_q.push_back(m);
      peer_tx = m;
      peer_load = 1'b1;
      write_word(d);
      peer_load = 1'b0;
      wait_busy(1'b1);
      if (collide) begin
         tx_data = ~d;
         tx_valid = 1'b1;
         @(negedge clk);
         tx_valid = 1'b0;
      end
      for (int k = 0; k < 2 && half > 0; k++) begin
         s = sck_out;
         n = 0;
         while (sck_out === s && n < 100) begin
            @(negedge clk);
            n++;
         end
      end
      if (half > 0) check("half_period", 8'(n), 8'(half));
      wait_busy(1'b0);
      idle(2);
      check("full_flag", 8'(status.buffer_full_flag), 8'h01);
      check("int_flag", 8'(status.port_interrupt_flag), 8'h01);
      if (half > 0) check("peer_rx", peer_rx, d);
      if (dbl === 1'b1) check("second_word", buffer_register, m);
      if (collide) check("collision", 8'(status.write_collision_flag), 8'h01);
   endtask
   task automatic bus(input logic c, input logic d);
      m_scl_low = c;
      m_sda_low = d;
      idle(10);
   endtask
   task automatic i2c_addr(input logic [7:0] a, output logic got);
      bus(1'b0, 1'b1);
      bus(1'b1, 1'b1);
      for (int b = 7; b >= 0; b--) begin
         bus(1'b1, ~a[b]);
         bus(1'b0, ~a[b]);
         bus(1'b1, ~a[b]);
      end
      bus(1'b1, 1'b0);
      bus(1'b0, 1'b0);
      got = ~sda_w;
      bus(1'b1, 1'b0);
      bus(1'b1, 1'b1);
      bus(1'b0, 1'b1);
      bus(1'b0, 1'b0);
   endtask

   // ----
   // result watcher and hang guard
   // ----
   always @(posedge status.buffer_full_flag) begin
      if (exp_q.size() > 0) begin
         @(negedge clk);
         check("buffer_register", buffer_register, exp_q.pop_front());
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         report_and_stop();
      end
   end

   // ----
   // main sequence
   // ----
   initial begin
      seed = 32'hDE14;
      repeat (8) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      idle(4);
      check("status_rst", status, 8'h00);
      check("buf_rst", buffer_register, 8'h00);
      // all four clock modes; the third word is left unread on purpose
      for (int i = 0; i < 5; i++) begin
         cfg.enable = 1'b1;
         cfg.master = 1'b1;
         cfg.clk_idle_high = i[1];
         cfg.out_on_active = i[0];
         cfg.sample_end = (i == 4);
         cfg.clk_rate = i[0] ? 2'h2 : 2'h1;
         idle(4);
         check("sck_idle", 8'(sck_out), 8'(cfg.clk_idle_high));
         check("sck_oe", 8'(sck_oe), 8'h01);
         spi_xfer(8'($random(seed)), i[0] ? 32 : 8, i == 4);
         if (i == 4) idle(20);
         if (i == 4) check("collision_kept", 8'(status.write_collision_flag), 8'h01);
         if (i != 2) clear_flags();
      end
      check("collision_clr", 8'(status.write_collision_flag), 8'h00);
      // slave: link clock comes from the bench, only within the frame
      cfg.master = 1'b0;
      cfg.use_select = 1'b1;
      cfg.clk_idle_high = 1'b0;
      cfg.out_on_active = 1'b0;
      cfg.sample_end = 1'b0;
      select_n = 1'b0;
      idle(4);
      check("sck_oe_slave", 8'(sck_oe), 8'h00);
      fork
         spi_xfer(8'($random(seed)), 0, 1'b0);
         begin
            idle(20);
            #7;
            repeat (8) begin
               #80 lk = 1'b1;
               #80 lk = 1'b0;
            end
         end
      join
      clear_flags();
      select_n = 1'b1;
      // i2c slave addressing, then master start and disable
      cfg = '0;
      cfg.enable = 1'b1;
      cfg.i2c_mode = 1'b1;
      cfg.general_call_enable = 1'b1;
      cfg.ten_bit = 1'b1;
      own = {5'b11110, 2'($random(seed)), 1'b0};
      idle(4);
      exp_q.push_back(8'h00);
      i2c_addr(8'h00, ack);
      check("gc_ack", 8'(ack), 8'h01);
      check("gc_hit", 8'(status.gcall_hit), 8'h01);
      check("gc_int", 8'(status.port_interrupt_flag), 8'h01);
      check("gc_no_ua", 8'(status.update_address_flag), 8'h00);
      check("stop_seen", 8'(status.stop_seen), 8'h01);
      clear_flags();
      cfg.general_call_enable = 1'b0;
      i2c_addr(8'h00, ack);
      check("gc_off_ack", 8'(ack), 8'h00);
      check("gc_off_full", 8'(status.buffer_full_flag), 8'h00);
      clear_flags();
      i2c_addr(own, ack);
      check("own_ack", 8'(ack), 8'h01);
      check("ua_set", 8'(status.update_address_flag), 8'h01);
      clear_flags();
      cfg.master = 1'b1;
      start_req = 1'b1;
      idle(3);
      check("bus_free", 8'(bus_granted), 8'h01);
      idle(6);
      check("m_lines", {6'h00, scl_oe, sda_oe}, 8'h03);
      check("m_start_int", 8'(status.port_interrupt_flag), 8'h01);
      check("bus_taken", 8'(bus_granted), 8'h00);
      start_req = 1'b0;
      cfg.enable = 1'b0;
      idle(3);
      check("start_clr", 8'(status.start_seen), 8'h00);
      check("stop_clr", 8'(status.stop_seen), 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
